// >>> rtl/tw_eeprom_slave.sv
// Two-wire serial EEPROM slave: bus engine, page buffer and self-timed write
`timescale 1ns/1ps

// Contract
// - Array holds 1024 bytes, written in pages of sixteen bytes.
// - Partial pages program only received bytes; others stay unchanged.
// - Programming is self-timed and ends within five milliseconds.
// - Bus ignored while power-good low; its rise resets control to standby.
// - Power-good drop forces standby and stops any write.
// - After stop, standby only when no programming cycle runs.
// - Data line only pulled low or released, never driven high.
// - Only the third strap takes part in address matching.
// - Floating strap reads as zero; two devices per bus.
// - Write-lock high makes the array read-only.
// - Write-lock low or floating allows normal writes.
// - Bytes go: slave address, operation bit, memory address, data.
// - All bit transfers follow the master's serial clock.
// - Only slave address bytes with upper nibble 1010 are acknowledged.
// - Two bits pick a 256-byte block, one bit matches strap, last is read.
// - Page write increments low four address bits, wrapping in the page.
// - No address acknowledge while programming; acknowledge again after.
module tw_eeprom_slave #(
    parameter int PROG_CYCLES = tw_pkg::PROG_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Serial bus
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // Straps and supply
    input  wire logic chip_select_strap,
    input  wire logic unused_addr_in_low,
    input  wire logic unused_addr_in_high,
    input  wire logic write_lock,
    input  wire logic power_good,
    // Status
    output logic      busy,
    output logic      standby
);
    import tw_pkg::*;

    function automatic logic [ADDR_W-1:0] inc_addr(input logic [ADDR_W-1:0] a);
        inc_addr = ADDR_W'(a + 1'b1);
    endfunction : inc_addr

    tw_pins_t                pin_raw;
    tw_pins_t                pin_meta;
    tw_pins_t                pin;
    tw_pins_t                pin_prev;
    logic                    scl_rise;
    logic                    scl_fall;
    logic                    start_det;
    logic                    stop_det;
    logic                    dev_match;

    tw_state_t               state;
    tw_state_t               next_state;
    tw_kind_t                kind;
    tw_kind_t                next_kind;
    logic [3:0]              bit_cnt;
    logic [3:0]              next_bit_cnt;
    logic [7:0]              shift;
    logic [7:0]              next_shift;
    logic                    got8;
    logic                    next_got8;
    logic                    is_read;
    logic                    next_is_read;
    logic                    mack;
    logic                    next_mack;
    logic [BLK_W-1:0]        blk;
    logic [BLK_W-1:0]        next_blk;
    logic [ADDR_W-1:0]       addr;
    logic [ADDR_W-1:0]       next_addr;
    logic [PAGE_NUM_W-1:0]   page;
    logic [PAGE_NUM_W-1:0]   next_page;
    logic [PAGE_BYTES-1:0]   mask;
    logic [PAGE_BYTES-1:0]   next_mask;
    logic [PROG_CNT_W-1:0]   prog_cnt;
    logic [PROG_CNT_W-1:0]   next_prog_cnt;
    logic                    next_sda_oe;

    logic                    buf_we;
    logic                    mem_we;
    logic [7:0]              rd_data;
    logic [7:0]              page_buf [PAGE_BYTES];
    logic [7:0]              mem [MEM_DEPTH];

    // Pin sampling, two stages before any use
    assign pin_raw = '{scl: scl_in, sda: sda_in, pg: power_good, lock: write_lock, strap: chip_select_strap};

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pin_meta <= '{scl: 1'b1, sda: 1'b1, pg: 1'b0, lock: 1'b0, strap: 1'b0};
            pin      <= '{scl: 1'b1, sda: 1'b1, pg: 1'b0, lock: 1'b0, strap: 1'b0};
            pin_prev <= '{scl: 1'b1, sda: 1'b1, pg: 1'b0, lock: 1'b0, strap: 1'b0};
        end
        else
        begin
            pin_meta <= pin_raw;
            pin      <= pin_meta;
            pin_prev <= pin;
        end
    end

    // Bus events from the master's clock
    assign scl_rise  = pin.scl && !pin_prev.scl;
    assign scl_fall  = !pin.scl && pin_prev.scl;
    assign start_det = pin.scl && pin_prev.scl && pin_prev.sda && !pin.sda;
    assign stop_det  = pin.scl && pin_prev.scl && !pin_prev.sda && pin.sda;
    // Upper nibble, third strap only, floating strap seen as low
    assign dev_match = (shift[CODE_MSB:CODE_LSB] == DEV_CODE)
                    && (shift[STRAP_BIT] == pin.strap);

    always_comb
    begin
        next_state    = state;
        next_kind     = kind;
        next_bit_cnt  = bit_cnt;
        next_shift    = shift;
        next_got8     = got8;
        next_is_read  = is_read;
        next_mack     = mack;
        next_blk      = blk;
        next_addr     = addr;
        next_page     = page;
        next_mask     = mask;
        next_prog_cnt = prog_cnt;
        next_sda_oe   = sda_oe;
        buf_we        = 1'b0;
        mem_we        = 1'b0;
        if (start_det && state != S_PROG)
        begin
            next_state   = S_RX;
            next_kind    = K_DEV;
            next_bit_cnt = 4'h0;
            next_got8    = 1'b0;
            next_sda_oe  = 1'b0;
        end
        else if (stop_det && state != S_PROG)
        begin
            next_sda_oe = 1'b0;
            if (mask != RST_MASK && !pin.lock)
            begin
                next_state    = S_PROG;
                next_prog_cnt = '0;
            end
            else
            begin
                next_state = S_IDLE;
                next_mask  = RST_MASK;
            end
        end
        else
        begin
            unique case (state)
                S_IDLE:
                begin
                end
                S_RX:
                begin
                    if (scl_rise && !got8)
                    begin
                        next_shift   = {shift[6:0], pin.sda};
                        next_bit_cnt = 4'(bit_cnt + 1'b1);
                        next_got8    = (bit_cnt == 4'h7);
                    end
                    else if (scl_fall && got8)
                    begin
                        next_got8    = 1'b0;
                        next_bit_cnt = 4'h0;
                        next_state   = S_ACK;
                        next_sda_oe  = 1'b1;
                        unique case (kind)
                            K_DEV:
                            begin
                                if (dev_match)
                                begin
                                    next_blk     = shift[BLK_MSB:BLK_LSB];
                                    next_is_read = shift[RW_BIT];
                                    next_kind    = K_WORD;
                                    if (!shift[RW_BIT])
                                    begin
                                        next_mask = RST_MASK;
                                    end
                                end
                                else
                                begin
                                    next_state  = S_IDLE;
                                    next_sda_oe = 1'b0;
                                end
                            end
                            K_WORD:
                            begin
                                next_addr = {blk, shift};
                                next_kind = K_DATA;
                            end
                            default:
                            begin
                                buf_we            = 1'b1;
                                next_mask[addr[PAGE_IDX_W-1:0]] = 1'b1;
                                next_page         = addr[ADDR_W-1:PAGE_IDX_W];
                                next_addr         = {addr[ADDR_W-1:PAGE_IDX_W],
                                                     PAGE_IDX_W'(addr[PAGE_IDX_W-1:0] + 1'b1)};
                            end
                        endcase
                    end
                end
                S_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (is_read && kind == K_WORD)
                        begin
                            next_state  = S_TX;
                            next_shift  = rd_data;
                            next_addr   = inc_addr(addr);
                            next_sda_oe = !rd_data[7];
                        end
                        else
                        begin
                            next_state  = S_RX;
                            next_sda_oe = 1'b0;
                        end
                    end
                end
                S_TX:
                begin
                    if (scl_fall)
                    begin
                        next_bit_cnt = 4'(bit_cnt + 1'b1);
                        if (bit_cnt == 4'h7)
                        begin
                            next_state  = S_MACK;
                            next_sda_oe = 1'b0;
                        end
                        else
                        begin
                            next_shift  = {shift[6:0], 1'b0};
                            next_sda_oe = !shift[6];
                        end
                    end
                end
                S_MACK:
                begin
                    if (scl_rise)
                    begin
                        next_mack = !pin.sda;
                    end
                    else if (scl_fall)
                    begin
                        next_bit_cnt = 4'h0;
                        if (mack)
                        begin
                            next_state  = S_TX;
                            next_shift  = rd_data;
                            next_addr   = inc_addr(addr);
                            next_sda_oe = !rd_data[7];
                        end
                        else
                        begin
                            next_state = S_IDLE;
                        end
                    end
                end
                S_PROG:
                begin
                    next_prog_cnt = PROG_CNT_W'(prog_cnt + 1'b1);
                    if (prog_cnt < PROG_CNT_W'(PAGE_BYTES))
                    begin
                        mem_we = mask[prog_cnt[PAGE_IDX_W-1:0]];
                    end
                    if (prog_cnt == PROG_CNT_W'(PROG_CYCLES - 1))
                    begin
                        next_state = S_IDLE;
                        next_mask  = RST_MASK;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst || !pin.pg)
        begin
            state    <= S_IDLE;
            kind     <= K_DEV;
            bit_cnt  <= 4'h0;
            shift    <= 8'h00;
            got8     <= 1'b0;
            is_read  <= 1'b0;
            mack     <= 1'b0;
            blk      <= 2'h0;
            addr     <= RST_ADDR;
            page     <= 6'h00;
            mask     <= RST_MASK;
            prog_cnt <= '0;
            sda_oe   <= 1'b0;
            busy     <= 1'b0;
            standby  <= 1'b1;
        end
        else
        begin
            state    <= next_state;
            kind     <= next_kind;
            bit_cnt  <= next_bit_cnt;
            shift    <= next_shift;
            got8     <= next_got8;
            is_read  <= next_is_read;
            mack     <= next_mack;
            blk      <= next_blk;
            addr     <= next_addr;
            page     <= next_page;
            mask     <= next_mask;
            prog_cnt <= next_prog_cnt;
            sda_oe   <= next_sda_oe;
            busy     <= (next_state == S_PROG);
            standby  <= (next_state == S_IDLE);
        end
    end

    // Open-drain: the output level is always low
    always_ff @(posedge core_clk)
    begin
        sda_out <= 1'b0;
    end

    // Page buffer and array
    always_ff @(posedge core_clk)
    begin
        if (buf_we)
        begin
            page_buf[addr[PAGE_IDX_W-1:0]] <= shift;
        end
        if (mem_we && pin.pg)
        begin
            mem[{page, prog_cnt[PAGE_IDX_W-1:0]}] <= page_buf[prog_cnt[PAGE_IDX_W-1:0]];
        end
        rd_data <= mem[addr];
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    AST_NO_HIGH_DRIVE: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    AST_PROG_BOUND: assert property (state == S_PROG |-> prog_cnt < PROG_CNT_W'(PROG_CYCLES))
        else $error("programming overran");
    AST_PG_LOW_IDLE: assert property (!pin.pg |=> state == S_IDLE && !sda_oe && !busy)
        else $error("active without power good");
    AST_PG_NO_WRITE: assert property (!pin.pg |=> !mem_we && !busy)
        else $error("write during power loss");
    AST_NO_ACK_BUSY: assert property (state == S_PROG |=> !sda_oe)
        else $error("acknowledge while busy");
    AST_LOCK_NO_PROG: assert property (stop_det && pin.lock && state != S_PROG && pin.pg
                                       |=> state != S_PROG)
        else $error("locked array programmed");
    AST_PAGE_WRAP: assert property (state == S_RX && scl_fall && got8 && kind == K_DATA && pin.pg
                                    |=> addr[ADDR_W-1:PAGE_IDX_W] == $past(addr[ADDR_W-1:PAGE_IDX_W])
                                        && addr[3:0] == 4'($past(addr[3:0]) + 1'b1))
        else $error("page address left page");
    AST_PROG_END: assert property (state == S_PROG && prog_cnt == PROG_CNT_W'(PROG_CYCLES - 1) && pin.pg
                                   |=> state == S_IDLE && standby)
        else $error("no standby after programming");
    AST_ADDR_MATCH: assert property (state == S_RX && kind == K_DEV && scl_fall && got8 && pin.pg
                                     ##1 sda_oe |-> $past(dev_match))
        else $error("ack to foreign address");
    AST_PARTIAL: assert property (mem_we |-> state == S_PROG && mask[prog_cnt[3:0]])
        else $error("unreceived byte programmed");

endmodule : tw_eeprom_slave

// >>> rtl/tw_pkg.sv
// Shared constants and types for the two-wire EEPROM slave
package tw_pkg;

    // Array organisation
    localparam int ADDR_W      = 10;
    localparam int MEM_DEPTH   = 1024;
    localparam int PAGE_BYTES  = 16;
    localparam int PAGE_IDX_W  = 4;
    localparam int PAGE_NUM_W  = 6;
    localparam int BLK_W       = 2;

    // Slave address byte layout
    localparam logic [3:0] DEV_CODE   = 4'ha;
    localparam int         CODE_MSB   = 7;
    localparam int         CODE_LSB   = 4;
    localparam int         STRAP_BIT  = 3;
    localparam int         BLK_MSB    = 2;
    localparam int         BLK_LSB    = 1;
    localparam int         RW_BIT     = 0;

    // Reset values
    localparam logic [ADDR_W-1:0]     RST_ADDR = 10'h000;
    localparam logic [PAGE_BYTES-1:0] RST_MASK = 16'h0000;

    // Self-timed programming cycle
    localparam int CLK_PERIOD_NS  = 40;
    localparam int PROG_TIME_NS   = 5000000;
    localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int PROG_CNT_W     = 17;

    typedef enum logic [2:0] {
        S_IDLE,
        S_RX,
        S_ACK,
        S_TX,
        S_MACK,
        S_PROG
    } tw_state_t;

    typedef enum logic [1:0] {
        K_DEV,
        K_WORD,
        K_DATA
    } tw_kind_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic pg;
        logic lock;
        logic strap;
    } tw_pins_t;

endpackage : tw_pkg

// >>> tb/tw_master.sv
// Two-wire bus master model that drives the serial clock and frames transfers
`timescale 1ns/1ps
module tw_master (
    // Clock
    input  wire logic core_clk,
    // Bus
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda_line
);
    logic sda_drv;

    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Pulled-up wired-AND line: released means high
    assign sda_line = sda_drv & ~sda_oe;

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask : wt

    // Clock idles high between frames; start leaves it low for the first bit
    task automatic start_cond;
        wt(2);
        sda_drv <= 1'b1;
        wt(2);
        scl <= 1'b1;
        wt(4);
        sda_drv <= 1'b0;
        wt(4);
        scl <= 1'b0;
    endtask : start_cond

    task automatic stop_cond;
        wt(2);
        sda_drv <= 1'b0;
        wt(2);
        scl <= 1'b1;
        wt(4);
        sda_drv <= 1'b1;
        wt(4);
    endtask : stop_cond

    // Data moves only while the clock is low
    task automatic bit_xfer(input logic b, output logic r);
        wt(2);
        sda_drv <= b;
        wt(2);
        scl <= 1'b1;
        wt(4);
        r = sda_line;
        scl <= 1'b0;
    endtask : bit_xfer

    // Byte out MSB first, then the acknowledge slot
    task automatic send_byte(input logic [7:0] d, output logic nack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_xfer(d[i], r);
        end
        bit_xfer(1'b1, nack);
    endtask : send_byte

    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_xfer(1'b1, d[i]);
        end
        bit_xfer(last, r);
    endtask : recv_byte
endmodule : tw_master

// >>> tb/tw_eeprom_slave_bench.sv
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/1ps
module tw_eeprom_slave_bench;
    import tw_pkg::*;

    localparam int PROG = 200;

    logic core_clk = 1'b0;
    logic rst;
    logic strap;
    logic a_low;
    logic a_high;
    logic lock;
    logic pg;
    logic scl;
    logic sda_line;
    logic sda_out;
    logic sda_oe;
    logic busy;
    logic standby;
    int bad_count = 0;
    int total_checks = 0;
    logic [7:0] exp_data [16];

    always #20 core_clk = ~core_clk;

    tw_eeprom_slave #(.PROG_CYCLES(PROG)) dut (
        .core_clk(core_clk),
        .rst(rst),
        .scl_in(scl),
        .sda_in(sda_line),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .chip_select_strap(strap),
        .unused_addr_in_low(a_low),
        .unused_addr_in_high(a_high),
        .write_lock(lock),
        .power_good(pg),
        .busy(busy),
        .standby(standby)
    );

    tw_master m (
        .core_clk(core_clk),
        .sda_oe(sda_oe),
        .scl(scl),
        .sda_line(sda_line)
    );

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    // Data pin value never goes high
    always @(posedge core_clk)
    begin
        if (!rst)
            check({7'h00, sda_out}, 8'h00);
    end

    task automatic probe(input logic [7:0] ab, input logic nack_exp);
        logic nack;
        m.start_cond();
        m.send_byte(ab, nack);
        m.stop_cond();
        check({7'h00, nack}, {7'h00, nack_exp});
    endtask : probe

    task automatic wr(input logic [7:0] ab, input logic [7:0] word, input int n, input logic [7:0] v);
        logic nack;
        m.start_cond();
        m.send_byte(ab, nack);
        check({7'h00, nack}, 8'h00);
        m.send_byte(word, nack);
        check({7'h00, nack}, 8'h00);
        for (int i = 0; i < n; i++)
        begin
            m.send_byte(v + 8'(i), nack);
            check({7'h00, nack}, 8'h00);
        end
        m.stop_cond();
    endtask : wr

    task automatic rd(input logic [7:0] ab, input logic [7:0] word, input int n);
        logic nack;
        logic [7:0] d;
        m.start_cond();
        m.send_byte(ab, nack);
        m.send_byte(word, nack);
        m.start_cond();
        m.send_byte(ab | 8'h01, nack);
        check({7'h00, nack}, 8'h00);
        for (int i = 0; i < n; i++)
        begin
            m.recv_byte(i == n - 1, d);
            check(d, exp_data[i]);
        end
        m.stop_cond();
    endtask : rd

    task automatic wait_idle;
        int cycles;
        cycles = 0;
        while (busy !== 1'b0)
        begin
            m.wt(1);
            cycles++;
            if (cycles > 4 * PROG)
            begin
                bad_count++;
                stop_test();
            end
        end
    endtask : wait_idle

    task automatic sc_power_up;
        check({5'h00, busy, standby, sda_oe}, 8'h02);
        pg <= 1'b0;
        m.wt(4);
        probe(8'ha0, 1'b1);
        check({7'h00, standby}, 8'h01);
        pg <= 1'b1;
        m.wt(8);
        probe(8'ha0, 1'b0);
    endtask : sc_power_up

    // Strap, unused inputs and expected refusal per address byte
    task automatic sc_address;
        logic [7:0] ab [6] = '{8'hb0, 8'ha8, 8'ha6, 8'haa, 8'ha2, 8'h20};
        logic [3:0] cfg [6] = '{4'h1, 4'h1, 4'h6, 4'h8, 4'h9, 4'h1};
        for (int i = 0; i < 6; i++)
        begin
            {strap, a_high, a_low} <= cfg[i][3:1];
            m.wt(4);
            probe(ab[i], cfg[i][0]);
        end
        {strap, a_high, a_low} <= 3'h0;
    endtask : sc_address

    task automatic sc_page;
        time t0;
        wr(8'ha4, 8'h30, 16, 8'h40);
        wait_idle();
        wr(8'ha4, 8'h3e, 3, 8'hc0);
        t0 = $time;
        check({6'h00, busy, standby}, 8'h02);
        probe(8'ha4, 1'b1);
        wait_idle();
        check({7'h00, ($time - t0) <= PROG * 40}, 8'h01);
        check({7'h00, standby}, 8'h01);
        probe(8'ha4, 1'b0);
        for (int i = 0; i < 16; i++)
        begin
            exp_data[i] = 8'h40 + 8'(i);
        end
        exp_data[0] = 8'hc2;
        exp_data[14] = 8'hc0;
        exp_data[15] = 8'hc1;
        rd(8'ha4, 8'h30, 16);
    endtask : sc_page

    task automatic sc_lock;
        lock <= 1'b1;
        wr(8'ha4, 8'h35, 1, 8'h5a);
        check({7'h00, busy}, 8'h00);
        lock <= 1'b0;
        probe(8'hb0, 1'b1);
        check({7'h00, busy}, 8'h00);
        exp_data[0] = 8'h45;
        rd(8'ha4, 8'h35, 1);
    endtask : sc_lock

    task automatic sc_power_drop;
        wr(8'ha4, 8'h36, 1, 8'h77);
        check({7'h00, busy}, 8'h01);
        pg <= 1'b0;
        m.wt(6);
        check({6'h00, busy, standby}, 8'h01);
        pg <= 1'b1;
        m.wt(8);
        probe(8'ha4, 1'b0);
    endtask : sc_power_drop

    initial
    begin
        rst    <= 1'b1;
        strap  <= 1'b0;
        a_low  <= 1'b0;
        a_high <= 1'b0;
        lock   <= 1'b0;
        pg     <= 1'b1;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        m.wt(8);
        sc_power_up();
        sc_address();
        sc_page();
        sc_lock();
        sc_power_drop();
        stop_test();
    end
endmodule : tw_eeprom_slave_bench
